//--- dv/i2c_hs_master_properties.sv
`timescale 1ns/1ps
`include "i2c_hs_consts.svh"
module i2c_hs_master_checker (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic scl_i,
    input wire logic scl_o,
    input wire logic scl_oe,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe,
    input wire logic irq
);
    // One clock domain, quiet during reset
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    // Read data stands only in the cycle after a read strobe
    AST_RDATA_QUIET: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data outside its slot");
    // Lines and interrupt idle at the first edge after reset
    AST_RESET_IDLE: assert property ($rose(arst_n) |-> !scl_oe && !sda_oe && !irq)
        else $error("active output right after reset");
    // Open drain: a driven line is always pulled low
    AST_PULL_LOW: assert property (scl_o == 1'b0 && sda_o == 1'b0)
        else $error("drive value not low");
    // A cleared mask silences the interrupt two cycles on
    AST_IRQ_MASKED: assert property (reg_wr && reg_addr == `REG_INTMASK && reg_wdata[2:0] == 3'h0 |-> ##2 !irq)
        else $error("interrupt high with mask cleared");
    // Lost arbitration shows as write flag, never read flag
    AST_LOSS_FLAGS: assert property ($past(reg_rd) && $past(reg_addr) == `REG_INTFLAG && reg_rdata[2]
        |-> reg_rdata[1:0] == 2'h2)
        else $error("arbitration loss flagged wrongly");
    // Every SCL low phase lasts eight cycles at least
    AST_SCL_LOW_MIN: assert property ($rose(scl_oe) |-> scl_oe [*8])
        else $error("SCL low phase too short");
    // SDA falls outside a low phase only as a start, with SCL high
    AST_START_SCL_HIGH: assert property ($rose(sda_oe) && !scl_oe |-> scl_i)
        else $error("start while SCL low");
    // A stop from the hold state frees both lines in bounded time
    AST_STOP_RELEASE: assert property (reg_wr && reg_addr == `REG_CMD && reg_wdata[1:0] == `CMD_STOP && scl_oe
        |-> ##[1:300] !scl_oe && !sda_oe)
        else $error("stop did not free the bus");

    // Main scenarios reached
    COV_IRQ: cover property ($rose(irq));
    COV_STOP: cover property (reg_wr && reg_addr == `REG_CMD && reg_wdata[1:0] == `CMD_STOP);
    COV_START: cover property ($rose(sda_oe) && !scl_oe);
endmodule

bind i2c_hs_master i2c_hs_master_checker i_chk (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .scl_i(scl_i),
    .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe), .irq(irq));

//--- dv/i2c_slave_model.sv
`timescale 1ns/1ps
module i2c_slave_model #(
    parameter logic [6:0] OWN_ADDR = 7'h52, // Address answered
    parameter logic [7:0] DATA0 = 8'h3c // First byte sent, then its inverse
) (
    input wire logic scl,
    input wire logic sda,
    input wire logic slow,
    output logic scl_oe,
    output logic sda_oe
);
    int cnt = 0; // Rising SCL edges in this byte
    logic [7:0] rx = 8'h00; // Bits shifted in
    logic [7:0] tx = 8'h00; // Byte being returned
    logic addr_ph = 1'b0; // Next byte is an address
    logic sel = 1'b0; // Addressed, transfer running
    logic rd = 1'b0; // Read direction
    logic odd = 1'b0; // Alternates returned data

    initial begin
        scl_oe = 1'b0;
        sda_oe = 1'b0;
    end
    // Start or repeated start: an address follows
    always @(negedge sda) begin
        if (scl === 1'b1) begin
            cnt = 0;
            addr_ph = 1'b1;
            sel = 1'b0;
        end
    end
    // Sample on rising SCL; a NACK from the master ends a read
    always @(posedge scl) begin
        if (cnt < 8) rx = {rx[6:0], sda};
        if (cnt == 8 && rd && sda) sel = 1'b0;
        cnt = cnt + 1;
    end
    // Drive only while SCL is low
    always @(negedge scl) begin
        if (cnt == 8 && addr_ph) begin
            addr_ph = 1'b0;
            sel = (rx[7:1] == OWN_ADDR);
            rd = rx[0];
            sda_oe = sel;
        end else if (cnt == 8) begin
            sda_oe = sel && !rd;
        end else if (cnt == 9) begin
            cnt = 0;
            tx = DATA0 ^ {8{odd}};
            if (sel && rd) odd = !odd;
            sda_oe = sel && rd && !tx[7];
        end else begin
            sda_oe = sel && rd && !tx[7 - cnt];
        end
        // Slow mode stretches SCL mid-byte
        if (cnt == 4 && slow) begin
            scl_oe = 1'b1;
            #400;
            scl_oe = 1'b0;
        end
    end
endmodule

//--- dv/testbench.sv
`timescale 1ns/1ps
`include "i2c_hs_consts.svh"
module testbench;
    logic clk = 1'b0; // System clock
    logic arst_n = 1'b0; // Reset, active low
    logic [7:0] reg_addr = 8'h00; // Register address
    logic [31:0] reg_wdata = 32'h0; // Write data
    logic reg_wr = 1'b0; // Write strobe
    logic reg_rd = 1'b0; // Read strobe
    logic grab = 1'b0; // Rival master on SDA
    logic slow = 1'b0; // Slave stretches SCL
    logic [31:0] reg_rdata;
    logic scl_o, scl_oe, sda_o, sda_oe, irq, s_scl_oe, s_sda_oe;
    int failures = 0; // Mismatches
    int checks_done = 0; // Comparisons
    int bitn = 0; // Bits in current byte
    int hi = 0; // SCL high time so far
    int hi_last = 0; // High time of last bit
    logic [8:0] sh = 9'h0; // Byte plus ack
    logic [8:0] seen[$]; // Bytes seen on the wire
    // Open-drain wires with pull-ups
    wire scl = (scl_oe ? scl_o : 1'b1) && !s_scl_oe;
    wire sda = (sda_oe ? sda_o : 1'b1) && !s_sda_oe && !grab;

    always #5 clk = ~clk;

    i2c_hs_master i_dut (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .scl_i(scl), .scl_o(scl_o),
        .scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .irq(irq));
    i2c_slave_model i_slave (.scl(scl), .sda(sda), .slow(slow), .scl_oe(s_scl_oe), .sda_oe(s_sda_oe));

    // Wire monitor: starts, bytes and high times
    always @(negedge sda) if (scl) bitn = 0;
    always @(posedge scl) begin
        sh = {sh[7:0], sda};
        bitn++;
        if (bitn == 9) begin
            seen.push_back(sh);
            bitn = 0;
        end
    end
    always @(posedge clk) hi <= scl ? hi + 1 : 0;
    always @(negedge scl) hi_last = hi;

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_reg(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
        logic [31:0] d;
        rd(a, d);
        check(d & m, exp);
    endtask
    // Bounded wait for the interrupt level
    task automatic wait_irq(input logic lvl);
        for (int n = 0; n < 20000 && irq !== lvl; n++) @(posedge clk);
        check({31'h0, irq}, {31'h0, lvl});
    endtask
    task automatic close_out;
        $display("Checks %0d, mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Watchdog well beyond the expected run
    initial begin
        #800000;
        failures++;
        close_out;
    end

    initial begin
        logic [31:0] st;
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        // Reset values, unmapped write ignored
        wr(8'h1c, 32'hffffffff);
        for (int i = 0; i < 8; i++) chk_reg(8'(i * 4), 32'hffffffff, 32'h0);
        check({31'h0, irq}, 32'h0);
        $display("test reset done");
        // High-speed read: master code, switch, two bytes
        wr(`REG_INTMASK, 32'h7);
        wr(`REG_CTRL, 32'h0d);
        wr(`REG_ADDR, 32'h00b);
        wait_irq(1'b1);
        chk_reg(`REG_INTFLAG, 32'h7, 32'h2);
        check({23'h0, seen[0]}, 32'h017);
        check(32'(hi_last >= 40 && hi_last <= 60), 32'h1);
        chk_reg(`REG_STATUS, 32'h5, 32'h0);
        wr(`REG_INTFLAG, 32'h7);
        wait_irq(1'b0);
        wr(`REG_ADDR, 32'h1a5);
        wait_irq(1'b1);
        chk_reg(`REG_INTFLAG, 32'h7, 32'h1);
        check({23'h0, seen[1]}, 32'h14a);
        check({23'h0, seen[2]}, 32'h078);
        check(32'(hi_last >= 10 && hi_last <= 25), 32'h1);
        chk_reg(`REG_STATUS, 32'h4, 32'h4);
        chk_reg(`REG_DATA, 32'hff, 32'h3c);
        wr(`REG_CTRL, 32'h1d);
        slow <= 1'b1;
        wr(`REG_INTFLAG, 32'h7);
        wait_irq(1'b0);
        wr(`REG_CMD, 32'h1);
        wait_irq(1'b1);
        check({23'h0, seen[3]}, 32'h187);
        chk_reg(`REG_DATA, 32'hff, 32'hc3);
        chk_reg(`REG_STATUS, 32'h4, 32'h4);
        wr(`REG_INTFLAG, 32'h7);
        wait_irq(1'b0);
        // Restart in high speed to write the slave, then one data byte
        wr(`REG_ADDR, 32'h1a4);
        wait_irq(1'b1);
        chk_reg(`REG_INTFLAG, 32'h7, 32'h2);
        check({23'h0, seen[4]}, 32'h148);
        wr(`REG_INTFLAG, 32'h7);
        wait_irq(1'b0);
        wr(`REG_DATA, 32'h5a);
        wait_irq(1'b1);
        check({23'h0, seen[5]}, 32'h0b4);
        chk_reg(`REG_STATUS, 32'h5, 32'h4);
        wr(`REG_INTFLAG, 32'h7);
        wait_irq(1'b0);
        wr(`REG_CMD, 32'h2);
        st = 32'h10;
        for (int n = 0; n < 100 && st[4] !== 1'b0; n++) rd(`REG_STATUS, st);
        chk_reg(`REG_STATUS, 32'h14, 32'h0);
        $display("test high speed done");
        // Arbitration lost on the first address bit
        slow <= 1'b0;
        wr(`REG_ADDR, 32'h0a4);
        for (int n = 0; n < 500 && scl !== 1'b0; n++) @(posedge clk);
        grab <= 1'b1;
        wait_irq(1'b1);
        chk_reg(`REG_INTFLAG, 32'h7, 32'h6);
        chk_reg(`REG_STATUS, 32'h2, 32'h2);
        grab <= 1'b0;
        $display("test arbitration done");
        // Mask and clear the interrupt
        wr(`REG_INTMASK, 32'h0);
        wait_irq(1'b0);
        wr(`REG_INTMASK, 32'h7);
        wait_irq(1'b1);
        wr(`REG_INTFLAG, 32'h7);
        wait_irq(1'b0);
        $display("test interrupt done");
        close_out;
    end
endmodule

//--- include/i2c_hs_consts.svh
`ifndef I2C_HS_CONSTS_SVH
`define I2C_HS_CONSTS_SVH

// Register byte offsets
`define REG_CTRL 8'h00
`define REG_ADDR 8'h04
`define REG_DATA 8'h08
`define REG_CMD 8'h0c
`define REG_INTFLAG 8'h10
`define REG_INTMASK 8'h14
`define REG_STATUS 8'h18

// Control field positions
`define CTRL_ENABLE 0
`define CTRL_SPEED_LO 1
`define CTRL_STRETCH 3
`define CTRL_ACKACT 4
`define CTRL_RESET 5'h00
`define SPEED_HIGH 2'h2

// Address register fields
`define HIGH_SPEED_ADDRESS_BIT_BIT 8
`define MCODE_PREFIX 5'h01

// Interrupt flag positions
`define INT_READ 0
`define INT_WRITE 1
`define INT_ERROR 2

// Commands written to the command register
`define CMD_READ 2'h1
`define CMD_STOP 2'h2

// Bit timing: half SCL periods in ns, clock in MHz
`define CLK_MHZ 100
`define FS_HALF_NS 500
`define HS_HALF_NS 150

`endif

//--- include/i2c_hs_pkg.sv
package i2c_hs_pkg;

    // Master sequencer states
    typedef enum logic [3:0] {
        ST_IDLE,
        ST_START,
        ST_BIT_LOW,
        ST_BIT_HIGH,
        ST_HOLD,
        ST_RS_LOW,
        ST_RS_HIGH,
        ST_STOP_LOW,
        ST_STOP_HIGH,
        ST_STOP_END
    } state_t;

endpackage

//--- rtl/i2c_hs_master.sv
// Local design decisions: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`include "i2c_hs_consts.svh"

module i2c_hs_master (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    output logic irq
);

    // Half-period cycle counts, least times rounded up
    localparam int FS_CYC_I = (`FS_HALF_NS * `CLK_MHZ + 999) / 1000;
    localparam int HS_CYC_I = (`HS_HALF_NS * `CLK_MHZ + 999) / 1000;
    localparam logic [7:0] FS_CYC = 8'(FS_CYC_I);
    localparam logic [7:0] HS_CYC = 8'(HS_CYC_I);

    // Pin synchronisers
    logic scl_m_q, scl_s_q;
    logic sda_m_q, sda_s_q;
    // Software registers
    logic [4:0] ctrl_q; // Enable, speed, stretch, ack action
    logic [7:0] addr_q; // Target address or master code
    logic hs_bit_q; // High-speed address bit
    logic [7:0] txd_q; // Byte to send
    logic [7:0] rxd_q; // Last received byte
    logic [2:0] flag_q; // Sticky interrupt flags
    logic [2:0] mask_q; // Interrupt mask
    // Sequencer state
    i2c_hs_pkg::state_t st_q;
    logic [7:0] cnt_q; // Half-period timer
    logic cnt_done;
    logic timing_go; // Timer may run
    logic [3:0] bit_q; // Bit index, 8 is the ack slot
    logic [7:0] sh_q; // Shift register
    logic tx_q; // Byte is sent by us
    logic is_addr_q; // Byte is an address
    logic mcode_q; // Byte is the master code
    logic read_dir_q; // Transfer reads from slave
    logic ack_pend_q; // Ack slot still owed to slave
    logic hs_pend_q; // Master code done, switch allowed
    logic hs_q; // Bus is in high-speed mode
    logic rxnack_q; // Last address or data got NACK
    logic arb_q; // Arbitration lost seen
    // Set pulses for the sticky flags
    logic set_read, set_write, set_err;
    // Decoded software strobes
    logic wr_ctrl, wr_addr, wr_data, wr_cmd, wr_flag, wr_mask;
    logic en;
    logic bit_out;
    logic arb_lost;

    assign en = ctrl_q[`CTRL_ENABLE];
    assign wr_ctrl = reg_wr && (reg_addr == `REG_CTRL);
    assign wr_addr = reg_wr && (reg_addr == `REG_ADDR);
    assign wr_data = reg_wr && (reg_addr == `REG_DATA);
    assign wr_cmd = reg_wr && (reg_addr == `REG_CMD);
    assign wr_flag = reg_wr && (reg_addr == `REG_INTFLAG);
    assign wr_mask = reg_wr && (reg_addr == `REG_INTMASK);

    // Two-flop synchronisers on the bus lines
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            scl_m_q <= 1'b1;
            scl_s_q <= 1'b1;
            sda_m_q <= 1'b1;
            sda_s_q <= 1'b1;
        end else begin
            scl_m_q <= scl_i;
            scl_s_q <= scl_m_q;
            sda_m_q <= sda_i;
            sda_s_q <= sda_m_q;
        end
    end

    // Control, address, data and mask registers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_q <= `CTRL_RESET;
            addr_q <= 8'h00;
            hs_bit_q <= 1'b0;
            txd_q <= 8'h00;
            mask_q <= 3'h0;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= reg_wdata[4:0];
            end
            if (wr_addr) begin
                addr_q <= reg_wdata[7:0];
                hs_bit_q <= reg_wdata[`HIGH_SPEED_ADDRESS_BIT_BIT];
            end
            if (wr_data) begin
                txd_q <= reg_wdata[7:0];
            end
            if (wr_mask) begin
                mask_q <= reg_wdata[2:0];
            end
        end
    end

    // Sticky flags: hardware set wins over write-one clear
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            flag_q <= 3'h0;
        end else begin
            flag_q <= (flag_q & ~(wr_flag ? reg_wdata[2:0] : 3'h0)) | {set_err, set_write, set_read};
        end
    end

    // Level interrupt from unmasked flags
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(flag_q & mask_q);
        end
    end

    // Register read data, one cycle after the strobe
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            case (reg_addr)
                `REG_CTRL: reg_rdata <= {27'h0, ctrl_q};
                `REG_ADDR: reg_rdata <= {23'h0, hs_bit_q, addr_q};
                `REG_DATA: reg_rdata <= {24'h0, rxd_q};
                `REG_INTFLAG: reg_rdata <= {29'h0, flag_q};
                `REG_INTMASK: reg_rdata <= {29'h0, mask_q};
                `REG_STATUS: begin
                    reg_rdata <= {27'h0, st_q != i2c_hs_pkg::ST_IDLE, st_q == i2c_hs_pkg::ST_HOLD,
                                  hs_q, arb_q, rxnack_q};
                end
                default: reg_rdata <= 32'h0000_0000; // Unmapped reads zero
            endcase
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

    // Timer waits for SCL to rise while released, allowing slave stretch
    assign timing_go = (st_q != i2c_hs_pkg::ST_BIT_HIGH && st_q != i2c_hs_pkg::ST_RS_HIGH
                        && st_q != i2c_hs_pkg::ST_STOP_HIGH) || scl_s_q;
    assign cnt_done = timing_go && (cnt_q == 8'h00);

    // Bit to place on SDA in the low phase
    always_comb begin
        if (bit_q == 4'd8) begin
            bit_out = tx_q ? 1'b1 : ctrl_q[`CTRL_ACKACT];
        end else begin
            bit_out = tx_q ? sh_q[7] : 1'b1;
        end
    end

    // Released high but seen low during a sent bit, full speed only
    assign arb_lost = tx_q && (bit_q != 4'd8) && sh_q[7] && !sda_s_q && !hs_q;

    // Half-period timer, reloaded on every state step
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q <= 8'h00;
        end else if (st_q == i2c_hs_pkg::ST_IDLE || st_q == i2c_hs_pkg::ST_HOLD || cnt_done) begin
            cnt_q <= hs_q ? HS_CYC : FS_CYC;
        end else if (timing_go) begin
            cnt_q <= cnt_q - 8'h01;
        end
    end

    // Main sequencer
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_q <= i2c_hs_pkg::ST_IDLE;
            bit_q <= 4'h0;
            sh_q <= 8'h00;
            tx_q <= 1'b0;
            is_addr_q <= 1'b0;
            mcode_q <= 1'b0;
            read_dir_q <= 1'b0;
            ack_pend_q <= 1'b0;
            hs_pend_q <= 1'b0;
            hs_q <= 1'b0;
            rxnack_q <= 1'b0;
            arb_q <= 1'b0;
            rxd_q <= 8'h00;
            scl_oe <= 1'b0;
            sda_oe <= 1'b0;
            set_read <= 1'b0;
            set_write <= 1'b0;
            set_err <= 1'b0;
        end else begin
            set_read <= 1'b0;
            set_write <= 1'b0;
            set_err <= 1'b0;
            case (st_q)
                i2c_hs_pkg::ST_IDLE: begin
                    // Address write starts a transfer at full speed
                    hs_q <= 1'b0;
                    hs_pend_q <= 1'b0;
                    scl_oe <= 1'b0;
                    sda_oe <= 1'b0;
                    if (wr_addr && en) begin
                        sh_q <= reg_wdata[7:0];
                        read_dir_q <= reg_wdata[0];
                        mcode_q <= !reg_wdata[`HIGH_SPEED_ADDRESS_BIT_BIT] && (reg_wdata[7:3] == `MCODE_PREFIX);
                        tx_q <= 1'b1;
                        is_addr_q <= 1'b1;
                        bit_q <= 4'h0;
                        arb_q <= 1'b0;
                        sda_oe <= 1'b1; // Start: SDA falls while SCL high
                        st_q <= i2c_hs_pkg::ST_START;
                    end
                end
                i2c_hs_pkg::ST_START: begin
                    if (cnt_done) begin
                        scl_oe <= 1'b1;
                        st_q <= i2c_hs_pkg::ST_BIT_LOW;
                    end
                end
                i2c_hs_pkg::ST_BIT_LOW: begin
                    // SCL low: present the bit, then release SCL
                    sda_oe <= !bit_out;
                    if (cnt_done) begin
                        scl_oe <= 1'b0;
                        st_q <= i2c_hs_pkg::ST_BIT_HIGH;
                    end
                end
                i2c_hs_pkg::ST_BIT_HIGH: begin
                    if (arb_lost && scl_s_q) begin
                        // Lost: release bus, set write and error flags
                        scl_oe <= 1'b0;
                        sda_oe <= 1'b0;
                        arb_q <= 1'b1;
                        set_write <= 1'b1;
                        set_err <= 1'b1;
                        st_q <= i2c_hs_pkg::ST_IDLE;
                    end else if (cnt_done) begin
                        scl_oe <= 1'b1;
                        if (bit_q != 4'd8) begin
                            sh_q <= {sh_q[6:0], sda_s_q};
                            if (bit_q == 4'd7 && !tx_q && !ctrl_q[`CTRL_STRETCH]) begin
                                // No stretch mode: flag before the ack slot
                                rxd_q <= {sh_q[6:0], sda_s_q};
                                set_read <= 1'b1;
                                ack_pend_q <= 1'b1;
                                bit_q <= 4'd8;
                                st_q <= i2c_hs_pkg::ST_HOLD;
                            end else begin
                                bit_q <= bit_q + 4'h1;
                                st_q <= i2c_hs_pkg::ST_BIT_LOW;
                            end
                        end else if (mcode_q) begin
                            // Master code NACK done at full speed
                            mcode_q <= 1'b0;
                            hs_pend_q <= 1'b1;
                            set_write <= 1'b1;
                            st_q <= i2c_hs_pkg::ST_HOLD;
                        end else if (tx_q) begin
                            rxnack_q <= sda_s_q;
                            is_addr_q <= 1'b0;
                            if (is_addr_q && read_dir_q && !sda_s_q) begin
                                // Address acked for a read: receive at once
                                tx_q <= 1'b0;
                                bit_q <= 4'h0;
                                st_q <= i2c_hs_pkg::ST_BIT_LOW;
                            end else begin
                                set_write <= 1'b1;
                                st_q <= i2c_hs_pkg::ST_HOLD;
                            end
                        end else if (ctrl_q[`CTRL_STRETCH]) begin
                            // Byte in and ack driven, then flag
                            rxd_q <= sh_q;
                            set_read <= 1'b1;
                            st_q <= i2c_hs_pkg::ST_HOLD;
                        end else if (ctrl_q[`CTRL_ACKACT]) begin
                            st_q <= i2c_hs_pkg::ST_HOLD; // NACK ends reception
                        end else begin
                            bit_q <= 4'h0;
                            st_q <= i2c_hs_pkg::ST_BIT_LOW;
                        end
                    end
                end
                i2c_hs_pkg::ST_HOLD: begin
                    // SCL held low until software acts
                    scl_oe <= 1'b1;
                    if (wr_addr && en) begin
                        sh_q <= reg_wdata[7:0];
                        read_dir_q <= reg_wdata[0];
                        tx_q <= 1'b1;
                        is_addr_q <= 1'b1;
                        bit_q <= 4'h0;
                        ack_pend_q <= 1'b0;
                        if (hs_pend_q && reg_wdata[`HIGH_SPEED_ADDRESS_BIT_BIT]) begin
                            hs_q <= 1'b1;
                        end
                        hs_pend_q <= 1'b0;
                        st_q <= i2c_hs_pkg::ST_RS_LOW;
                    end else if (wr_data && en && !read_dir_q) begin
                        sh_q <= reg_wdata[7:0];
                        tx_q <= 1'b1;
                        bit_q <= 4'h0;
                        st_q <= i2c_hs_pkg::ST_BIT_LOW;
                    end else if (wr_cmd && reg_wdata[1:0] == `CMD_READ && read_dir_q) begin
                        tx_q <= 1'b0;
                        bit_q <= ack_pend_q ? 4'd8 : 4'h0;
                        ack_pend_q <= 1'b0;
                        st_q <= i2c_hs_pkg::ST_BIT_LOW;
                    end else if (wr_cmd && reg_wdata[1:0] == `CMD_STOP) begin
                        ack_pend_q <= 1'b0;
                        sda_oe <= 1'b1;
                        st_q <= i2c_hs_pkg::ST_STOP_LOW;
                    end
                end
                i2c_hs_pkg::ST_RS_LOW: begin
                    // Release SDA with SCL low, timed at the speed loaded in hold; a switch applies from the next phase
                    sda_oe <= 1'b0;
                    if (cnt_done) begin
                        scl_oe <= 1'b0;
                        st_q <= i2c_hs_pkg::ST_RS_HIGH;
                    end
                end
                i2c_hs_pkg::ST_RS_HIGH: begin
                    if (cnt_done) begin
                        sda_oe <= 1'b1;
                        st_q <= i2c_hs_pkg::ST_START;
                    end
                end
                i2c_hs_pkg::ST_STOP_LOW: begin
                    if (cnt_done) begin
                        scl_oe <= 1'b0;
                        st_q <= i2c_hs_pkg::ST_STOP_HIGH;
                    end
                end
                i2c_hs_pkg::ST_STOP_HIGH: begin
                    if (cnt_done) begin
                        sda_oe <= 1'b0;
                        st_q <= i2c_hs_pkg::ST_STOP_END;
                    end
                end
                i2c_hs_pkg::ST_STOP_END: begin
                    // High speed ends only with the stop
                    if (cnt_done) begin
                        hs_q <= 1'b0;
                        st_q <= i2c_hs_pkg::ST_IDLE;
                    end
                end
                default: begin
                    st_q <= i2c_hs_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Open-drain drive value is always low
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            scl_o <= 1'b0;
            sda_o <= 1'b0;
        end else begin
            scl_o <= 1'b0;
            sda_o <= 1'b0;
        end
    end

endmodule
